// *** pkg/acsalu_map.svh ***
`ifndef ACSALU_MAP_SVH
`define ACSALU_MAP_SVH

// Accumulator limits and reset value
`define ACS_ACC_RESET  32'h0000_0000
`define ACS_MAX_POS    32'h7FFF_FFFF
`define ACS_MAX_NEG    32'h8000_0000

// Incoming shifter range and the fixed high-half shift
`define ACS_SHIFT_MAX  5'h10
`define ACS_SHIFT_HIGH 5'h10

// Store-upper-half shift codes that are honoured
`define ACS_STORE_UPPER_HALF_INSTR_SH0   5'h00
`define ACS_STORE_UPPER_HALF_INSTR_SH1   5'h01
`define ACS_STORE_UPPER_HALF_INSTR_SH4   5'h04

// Status word field positions used by the load-status instruction
`define ACS_ST_SAT_BIT 11
`define ACS_ST_OV_BIT  12

// Last on-chip RAM address, no move beyond it
`define ACS_RAM_LAST   8'hFF

`endif

// *** pkg/acsalu_pkg.sv ***
package acsalu_pkg;

   // Decoded instruction, one-hot
   typedef enum logic [16:0] {
      ACS_NOP      = 17'h0_0001,
      ACS_LOAD_SH  = 17'h0_0002,
      ACS_ADD_SH   = 17'h0_0004,
      ACS_SUB_SH   = 17'h0_0008,
      ACS_ZERO_LDH = 17'h0_0010,
      ACS_ADD_H    = 17'h0_0020,
      ACS_SUB_H    = 17'h0_0040,
      ACS_AND      = 17'h0_0080,
      ACS_OR       = 17'h0_0100,
      ACS_XOR      = 17'h0_0200,
      ACS_STORE_H  = 17'h0_0400,
      ACS_SET_SAT  = 17'h0_0800,
      ACS_CLR_SAT  = 17'h0_1000,
      ACS_LOAD_ST  = 17'h0_2000,
      ACS_BR_OV    = 17'h0_4000,
      ACS_MOVE     = 17'h0_8000,
      ACS_LDT_MOVE = 17'h1_0000
   } acsalu_op_t;

   // One instruction from the sequencer with its fetched RAM word
   typedef struct packed {
      acsalu_op_t  op;
      logic [4:0]  shift;
      logic [15:0] data;
      logic [7:0]  addr;
   } acsalu_req_t;

   // Status bits seen by the sequencer
   typedef struct packed {
      logic sat_en;
      logic ovf;
   } acsalu_status_t;

   // Write port toward on-chip RAM
   typedef struct packed {
      logic        valid;
      logic [7:0]  addr;
      logic [15:0] data;
   } acsalu_memwr_t;

endpackage

// *** rtl/acsalu_shifter.sv ***
// Arithmetic left shift of a signed operand into accumulator width
module acsalu_shifter #(
   parameter int IW = 16,
   parameter int OW = 32,
   parameter int SW = 5
) (
   input  wire logic [IW-1:0] data_i,
   input  wire logic [SW-1:0] amount_i,
   output logic      [OW-1:0] shifted_o
);

   logic [OW-1:0] ext;

   // Sign bit fills every vacated upper bit
   assign ext       = {{(OW-IW){data_i[IW-1]}}, data_i};
   assign shifted_o = ext << amount_i;

endmodule

// *** rtl/acsalu_sat.sv ***
// Add or subtract with overflow detection and optional saturation
module acsalu_sat #(
   parameter int W = 32
) (
   input  wire logic [W-1:0] a_i,
   input  wire logic [W-1:0] b_i,
   input  wire logic         sub_i,
   input  wire logic         sat_en_i,
   output logic      [W-1:0] result_o,
   output logic              ovf_o
);

   logic [W:0]   sum;
   logic [W-1:0] max_pos;
   logic [W-1:0] max_neg;

   // One guard bit keeps the true sign of the result
   assign sum     = sub_i ? ({a_i[W-1], a_i} - {b_i[W-1], b_i})
                          : ({a_i[W-1], a_i} + {b_i[W-1], b_i});
   assign max_pos = {1'b0, {(W-1){1'b1}}};
   assign max_neg = {1'b1, {(W-1){1'b0}}};

   // Magnitude overflow only, never a carry out
   assign ovf_o = sum[W] ^ sum[W-1];

   // Clamp toward the true sign when saturation is on
   always_comb begin
      if (ovf_o && sat_en_i) begin
         result_o = sum[W] ? max_neg : max_pos;
      end else begin
         result_o = sum[W-1:0];
      end
   end

endmodule

// *** rtl/acsalu_top.sv ***
// Summary of operation
// - With saturation on, an overflow becomes 7FFFFFFFh if positive, 80000000h if negative.
// - Set and clear instructions and load-status alone change the saturation bit.
// - The overflow flag sets from arithmetic only on magnitude overflow, never as a carry, also loads from load-status, and is sticky.
// - A branch that tests the overflow flag clears it while it executes.
// - The branch-on-overflow instruction is taken when the flag is set, after any arithmetic.
// - Saturation, when on, covers every arithmetic accumulator operation.
// - The memory-to-accumulator path shifts the operand left by 0 to 16 from the instruction.
// - The incoming shifter sign-extends the 16-bit operand into the vacated upper bits.
// - Load, add and subtract from data memory all take the shifted operand.
// - Zero-load-high, add-high and subtract-high place the operand in the upper half.
// - Store-upper-half shifts the accumulator by 0, 1 or 4 only before writing bits 31 to 16.
// - AND, OR and XOR combine the accumulator with a RAM word to set, clear or test bits.
// - The data move copies the addressed RAM word to the next address in the same cycle.
// - Move and load-multiplicand-with-move trigger the data move, on-chip RAM only.
`include "acsalu_map.svh"

module acsalu_top #(
   parameter int ACC_W = 32,
   parameter int DAT_W = 16,
   parameter int SH_W  = 5
) (
   input  wire logic                   clk_i,
   input  wire logic                   reset_n_i,
   input  wire acsalu_pkg::acsalu_req_t req_i,
   output logic [31:0]                 acc_o,
   output acsalu_pkg::acsalu_status_t  status_o,
   output logic                        branch_taken_o,
   output acsalu_pkg::acsalu_memwr_t   mem_wr_o
);
   import acsalu_pkg::*;

   logic [31:0] acc_reg;
   logic [31:0] acc_next;
   logic        ovf_reg;
   logic        sat_reg;
   logic        branch_reg;
   logic [4:0]  shift_amt;
   logic [31:0] shifted;
   logic        arith_sub;
   logic        arith_op;
   logic [31:0] arith_res;
   logic        arith_ovf;
   logic [31:0] logic_opnd;
   logic [31:0] store_upper_half_instr_shifted;
   logic        move_op;

   // Shift amount: high-half forms fix it at 16, larger fields clamp
   always_comb begin
      unique case (req_i.op)
         ACS_ZERO_LDH, ACS_ADD_H, ACS_SUB_H: begin
            shift_amt = `ACS_SHIFT_HIGH;
         end
         default: begin
            shift_amt = (req_i.shift > `ACS_SHIFT_MAX) ? `ACS_SHIFT_MAX : req_i.shift;
         end
      endcase
   end

   acsalu_shifter #(
      .IW (DAT_W),
      .OW (ACC_W),
      .SW (SH_W)
   ) u_shifter (
      .data_i    (req_i.data),
      .amount_i  (shift_amt),
      .shifted_o (shifted)
   );

   // Every add or subtract goes through the one saturating adder
   assign arith_op  = (req_i.op == ACS_ADD_SH) || (req_i.op == ACS_SUB_SH) ||
                      (req_i.op == ACS_ADD_H)  || (req_i.op == ACS_SUB_H);
   assign arith_sub = (req_i.op == ACS_SUB_SH) || (req_i.op == ACS_SUB_H);

   acsalu_sat #(
      .W (ACC_W)
   ) u_sat (
      .a_i      (acc_reg),
      .b_i      (shifted),
      .sub_i    (arith_sub),
      .sat_en_i (sat_reg),
      .result_o (arith_res),
      .ovf_o    (arith_ovf)
   );

   // Logic operand is zero-extended so upper bits clear on AND
   assign logic_opnd = {16'h0000, req_i.data};

   // Next accumulator, final value already saturated
   always_comb begin
      unique case (req_i.op)
         ACS_LOAD_SH:  acc_next = shifted;
         ACS_ADD_SH,
         ACS_SUB_SH:   acc_next = arith_res;
         ACS_ZERO_LDH: acc_next = shifted;
         ACS_ADD_H,
         ACS_SUB_H:    acc_next = arith_res;
         ACS_AND:      acc_next = acc_reg & logic_opnd;
         ACS_OR:       acc_next = acc_reg | logic_opnd;
         ACS_XOR:      acc_next = acc_reg ^ logic_opnd;
         default:      acc_next = acc_reg;
      endcase
   end

   // Accumulator
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         acc_reg <= `ACS_ACC_RESET;
      end else begin
         acc_reg <= acc_next;
      end
   end

   // Overflow flag: sticky, cleared by a test or reloaded by status
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ovf_reg <= 1'b0;
      end else if (arith_op && arith_ovf) begin
         ovf_reg <= 1'b1;
      end else if (req_i.op == ACS_BR_OV) begin
         ovf_reg <= 1'b0;
      end else if (req_i.op == ACS_LOAD_ST) begin
         ovf_reg <= req_i.data[`ACS_ST_OV_BIT];
      end
   end

   // Saturation mode bit
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         sat_reg <= 1'b0;
      end else begin
         unique case (req_i.op)
            ACS_SET_SAT: sat_reg <= 1'b1;
            ACS_CLR_SAT: sat_reg <= 1'b0;
            ACS_LOAD_ST: sat_reg <= req_i.data[`ACS_ST_SAT_BIT];
            default:     sat_reg <= sat_reg;
         endcase
      end
   end

   // Branch decision, one-cycle pulse after the branch instruction
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         branch_reg <= 1'b0;
      end else begin
         branch_reg <= (req_i.op == ACS_BR_OV) && ovf_reg;
      end
   end

   // Store shift: unsupported codes fall back to no shift
   always_comb begin
      unique case (req_i.shift)
         `ACS_STORE_UPPER_HALF_INSTR_SH1: store_upper_half_instr_shifted = acc_reg << `ACS_STORE_UPPER_HALF_INSTR_SH1;
         `ACS_STORE_UPPER_HALF_INSTR_SH4: store_upper_half_instr_shifted = acc_reg << `ACS_STORE_UPPER_HALF_INSTR_SH4;
         default:       store_upper_half_instr_shifted = acc_reg;
      endcase
   end

   // RAM write toward the current cycle, so a move overlaps the ALU work.
   // The last RAM word has no higher neighbour, so its move is dropped.
   assign move_op = (req_i.op == ACS_MOVE) || (req_i.op == ACS_LDT_MOVE);
   always_comb begin
      mem_wr_o = '0;
      if (req_i.op == ACS_STORE_H) begin
         mem_wr_o.valid = 1'b1;
         mem_wr_o.addr  = req_i.addr;
         mem_wr_o.data  = store_upper_half_instr_shifted[31:16];
      end else if (move_op && (req_i.addr != `ACS_RAM_LAST)) begin
         mem_wr_o.valid = 1'b1;
         mem_wr_o.addr  = req_i.addr + 8'h01;
         mem_wr_o.data  = req_i.data;
      end
   end

   assign acc_o           = acc_reg;
   assign status_o        = '{sat_en: sat_reg, ovf: ovf_reg};
   assign branch_taken_o  = branch_reg;

   // Positive overflow clamps to the top value
   a_sat_pos_value: assert property (
      @(posedge clk_i) disable iff (!reset_n_i)
      arith_op && sat_reg && arith_ovf && !arith_sub && !shifted[31]
      |=> acc_o == `ACS_MAX_POS)
      else $error("positive overflow did not saturate");

   // Negative overflow clamps to the bottom value
   a_sat_neg_value: assert property (
      @(posedge clk_i) disable iff (!reset_n_i)
      arith_op && sat_reg && arith_ovf && acc_reg[31] && (arith_sub ^ shifted[31])
      |=> acc_o == `ACS_MAX_NEG)
      else $error("negative overflow did not saturate");

   // Mode bit follows a set, then a clear on the next instruction
   a_sat_mode_ctl: assert property (
      @(posedge clk_i) disable iff (!reset_n_i)
      (req_i.op == ACS_SET_SAT) ##1 (req_i.op == ACS_CLR_SAT)
      |-> status_o.sat_en ##1 !status_o.sat_en)
      else $error("saturation bit did not follow set then clear");

   // Flag holds until a clearing instruction
   a_ovf_sticky: assert property (
      @(posedge clk_i) disable iff (!reset_n_i)
      ovf_reg && (req_i.op != ACS_BR_OV) && (req_i.op != ACS_LOAD_ST)
      |=> status_o.ovf)
      else $error("overflow flag dropped without a clear");

   // No flag from an in-range result
   a_ovf_no_carry: assert property (
      @(posedge clk_i) disable iff (!reset_n_i)
      !ovf_reg && (req_i.op == ACS_ADD_SH) && (acc_reg == 32'hFFFF_FFFF) &&
      (shifted == 32'h0000_0001)
      |=> !status_o.ovf && (acc_o == 32'h0000_0000))
      else $error("carry out raised the overflow flag");

   // Branch test clears the flag and reports the old value
   a_branch_clears: assert property (
      @(posedge clk_i) disable iff (!reset_n_i)
      (req_i.op == ACS_BR_OV) |=> !status_o.ovf && (branch_taken_o == $past(ovf_reg)))
      else $error("branch on overflow did not clear or report the flag");

   // Overflow from arithmetic makes the next branch taken
   a_branch_after_ovf: assert property (
      @(posedge clk_i) disable iff (!reset_n_i)
      arith_op && arith_ovf ##1 (req_i.op == ACS_BR_OV) |=> branch_taken_o)
      else $error("branch not taken after an overflow");

   // High-half add saturates like any other arithmetic
   a_sat_high_add: assert property (
      @(posedge clk_i) disable iff (!reset_n_i)
      (req_i.op == ACS_ADD_H) && sat_reg && arith_ovf
      |=> (acc_o == `ACS_MAX_POS) || (acc_o == `ACS_MAX_NEG))
      else $error("high-half add escaped saturation");

   // Shifted load is a sign-extended multiply by a power of two
   a_load_shift: assert property (
      @(posedge clk_i) disable iff (!reset_n_i)
      (req_i.op == ACS_LOAD_SH) && (req_i.shift == 5'h04)
      |=> acc_o == {{12{$past(req_i.data[15])}}, $past(req_i.data), 4'h0})
      else $error("shifted load value wrong");

   // High load leaves the low half zero
   a_zero_load_high: assert property (
      @(posedge clk_i) disable iff (!reset_n_i)
      (req_i.op == ACS_ZERO_LDH) |=> acc_o == {$past(req_i.data), 16'h0000})
      else $error("zero-load-high value wrong");

   // Store with shift of four takes bits 27 to 12
   a_store_shift: assert property (
      @(posedge clk_i) disable iff (!reset_n_i)
      (req_i.op == ACS_STORE_H) && (req_i.shift == 5'h04)
      |-> mem_wr_o.valid && (mem_wr_o.data == acc_reg[27:12]))
      else $error("store-upper-half shifted data wrong");

   // AND clears the upper half and masks the lower
   a_logic_and: assert property (
      @(posedge clk_i) disable iff (!reset_n_i)
      (req_i.op == ACS_AND)
      |=> acc_o == {16'h0000, $past(acc_reg[15:0]) & $past(req_i.data)})
      else $error("AND result wrong");

   // Move writes the next address in the same cycle
   a_move_next: assert property (
      @(posedge clk_i) disable iff (!reset_n_i)
      move_op && (req_i.addr != `ACS_RAM_LAST)
      |-> mem_wr_o.valid && (mem_wr_o.addr == req_i.addr + 8'h01) &&
          (mem_wr_o.data == req_i.data))
      else $error("data move write wrong");

   // Incoming shift above sixteen clamps to sixteen
   a_shift_clamp: assert property (
      @(posedge clk_i) disable iff (!reset_n_i)
      (req_i.op == ACS_LOAD_SH) && (req_i.shift > `ACS_SHIFT_MAX)
      |=> acc_o == {$past(req_i.data), 16'h0000})
      else $error("oversized load shift not clamped");

   // Unsaturated shifted subtract wraps like plain two's complement
   a_sub_shift: assert property (
      @(posedge clk_i) disable iff (!reset_n_i)
      (req_i.op == ACS_SUB_SH) && !sat_reg && (req_i.shift == 5'h00)
      |=> acc_o == $past(acc_reg) - {{16{$past(req_i.data[15])}}, $past(req_i.data)})
      else $error("shifted subtract value wrong");

   // OR keeps the upper half and sets lower bits
   a_logic_or: assert property (
      @(posedge clk_i) disable iff (!reset_n_i)
      (req_i.op == ACS_OR)
      |=> acc_o == ($past(acc_reg) | {16'h0000, $past(req_i.data)}))
      else $error("OR result wrong");

   // Branch result is a single-cycle pulse
   a_branch_pulse: assert property (
      @(posedge clk_i) disable iff (!reset_n_i)
      branch_taken_o |=> !branch_taken_o)
      else $error("branch result held beyond one cycle");

   // Move from the last address writes nothing
   a_move_last: assert property (
      @(posedge clk_i) disable iff (!reset_n_i)
      move_op && (req_i.addr == `ACS_RAM_LAST) |-> !mem_wr_o.valid)
      else $error("data move wrote past the last RAM word");

   // Flag and clamped value both visible to the next instruction
   a_ovf_same_cycle: assert property (
      @(posedge clk_i) disable iff (!reset_n_i)
      arith_op && arith_ovf && sat_reg
      |=> status_o.ovf && ((acc_o == `ACS_MAX_POS) || (acc_o == `ACS_MAX_NEG)))
      else $error("overflow not settled in the writing cycle");

endmodule

// *** tb/acsalu_ram_model.sv ***
// On-chip data RAM seen from the far side of the datapath write port
module acsalu_ram_model (
   input  wire logic                      clk_i,
   input  wire acsalu_pkg::acsalu_memwr_t wr_i,
   input  wire logic [7:0]                raddr_i,
   output logic       [15:0]              rdata_o
);
   timeunit 1ns;
   timeprecision 1ps;
   import acsalu_pkg::*;

   logic [15:0] mem_reg [256];

   // Non-zero fill, so a missing write never looks like a good copy
   initial begin
      for (int i = 0; i < 256; i++) begin
         mem_reg[i] = 16'hC3A5 ^ 16'(i);
      end
   end

   // Writes land at the clock edge that ends the instruction; plain always
   // because the fill above also writes this array
   always @(posedge clk_i) begin
      if (wr_i.valid === 1'b1) begin
         mem_reg[wr_i.addr] <= wr_i.data;
      end
   end

   // Combinational read of the addressed word
   assign rdata_o = mem_reg[raddr_i];
endmodule

// *** tb/acsalu_top_bench.sv ***
// Self-checking bench: reference model in integers against the datapath
module acsalu_top_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import acsalu_pkg::*;

   logic           clk_i = 1'b0;
   logic           reset_n_i = 1'b0;
   acsalu_req_t    req = '{op: ACS_NOP, shift: 5'h00, data: 16'h0000, addr: 8'h00};
   logic [31:0]    acc_o;
   acsalu_status_t status_o;
   logic           branch_taken_o;
   acsalu_memwr_t  mem_wr_o;
   logic [15:0]    ram_rdata;
   int             errors = 0;
   int             cmp_count = 0;
   logic [31:0]    m_acc = 32'h0000_0000;
   logic           m_sat = 1'b0;
   logic           m_ovf = 1'b0;
   logic           m_br = 1'b0;

   acsalu_top uut (
      .clk_i          (clk_i),
      .reset_n_i      (reset_n_i),
      .req_i          (req),
      .acc_o          (acc_o),
      .status_o       (status_o),
      .branch_taken_o (branch_taken_o),
      .mem_wr_o       (mem_wr_o)
   );

   acsalu_ram_model ram (
      .clk_i   (clk_i),
      .wr_i    (mem_wr_o),
      .raddr_i (req.addr),
      .rdata_o (ram_rdata)
   );

   // 100 MHz clock
   always #5 clk_i = ~clk_i;

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic print_verdict();
      $display("compares %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // One instruction per edge; results of the previous one checked meanwhile
   task automatic issue(input acsalu_op_t op, input logic [4:0] sh, input logic [15:0] d,
                        input logic [7:0] a);
      logic [31:0] b;
      logic [31:0] st;
      longint      s;
      int          k;
      logic        wv;
      logic [7:0]  wa;
      logic [15:0] wd;
      @(posedge clk_i);
      req <= '{op: op, shift: sh, data: d, addr: a};
      #1;
      chk("acc", m_acc, acc_o);
      chk("sat_en", 32'(m_sat), 32'(status_o.sat_en));
      chk("ovf", 32'(m_ovf), 32'(status_o.ovf));
      chk("branch", 32'(m_br), 32'(branch_taken_o));
      k = (sh > 5'h10) ? 16 : int'(sh);
      b = {{16{d[15]}}, d} << k;
      if (op inside {ACS_ADD_H, ACS_SUB_H}) begin
         b = {d, 16'h0000};
      end
      wv = 1'b0;
      wa = a;
      wd = d;
      m_br = 1'b0;
      case (op)
         ACS_LOAD_SH:  m_acc = b;
         ACS_ZERO_LDH: m_acc = {d, 16'h0000};
         ACS_AND:      m_acc = m_acc & {16'h0000, d};
         ACS_OR:       m_acc = m_acc | {16'h0000, d};
         ACS_XOR:      m_acc = m_acc ^ {16'h0000, d};
         ACS_SET_SAT:  m_sat = 1'b1;
         ACS_CLR_SAT:  m_sat = 1'b0;
         ACS_LOAD_ST:  {m_ovf, m_sat} = d[12:11];
         ACS_BR_OV:    {m_br, m_ovf} = {m_ovf, 1'b0};
         ACS_STORE_H: begin
            st = m_acc << ((sh == 5'h01 || sh == 5'h04) ? int'(sh) : 0);
            {wv, wd} = {1'b1, st[31:16]};
         end
         ACS_MOVE, ACS_LDT_MOVE: {wv, wa} = {a != 8'hFF, a + 8'h01};
         ACS_ADD_SH, ACS_SUB_SH, ACS_ADD_H, ACS_SUB_H: begin
            s = longint'($signed(b));
            if (op inside {ACS_SUB_SH, ACS_SUB_H}) begin
               s = -s;
            end
            s = s + longint'($signed(m_acc));
            m_acc = s[31:0];
            if (s > 64'sd2147483647 || s < -64'sd2147483648) begin
               m_ovf = 1'b1;
               if (m_sat) begin
                  m_acc = (s > 0) ? 32'h7FFF_FFFF : 32'h8000_0000;
               end
            end
         end
         default: ;
      endcase
      chk("wr_valid", 32'(wv), 32'(mem_wr_o.valid));
      if (wv) begin
         chk("wr_addr", 32'(wa), 32'(mem_wr_o.addr));
         chk("wr_data", 32'(wd), 32'(mem_wr_o.data));
      end
   endtask

   // Watchdog sized well past the expected 650 or so cycles
   initial begin
      #200000;
      errors++;
      print_verdict();
   end

   initial begin
      acsalu_op_t  op;
      logic [15:0] d;
      logic [7:0]  a;
      void'($urandom(32'h928c));
      repeat (8) @(posedge clk_i);
      reset_n_i <= 1'b1;
      // Reset values, then every shift amount including the clamp
      for (int k = 0; k < 18; k++) begin
         issue(ACS_LOAD_SH, 5'(k), 16'($urandom), 8'h10);
      end
      // Saturation both ways, overflow sticky until a branch clears it
      issue(ACS_SET_SAT, 5'h00, 16'h0000, 8'h00);
      issue(ACS_ZERO_LDH, 5'h00, 16'h7FFF, 8'h00);
      issue(ACS_ADD_H, 5'h00, 16'h7FFF, 8'h00);
      issue(ACS_LOAD_SH, 5'h00, 16'h0001, 8'h00);
      issue(ACS_SUB_H, 5'h00, 16'h7FFF, 8'h00);
      issue(ACS_SUB_H, 5'h00, 16'h7FFF, 8'h00);
      issue(ACS_BR_OV, 5'h00, 16'h0000, 8'h00);
      issue(ACS_BR_OV, 5'h00, 16'h0000, 8'h00);
      // Carry out of bit 31 is no overflow; mode set, clear, status load
      issue(ACS_LOAD_SH, 5'h00, 16'hFFFF, 8'h00);
      issue(ACS_ADD_SH, 5'h00, 16'h0001, 8'h00);
      issue(ACS_SET_SAT, 5'h00, 16'h0000, 8'h00);
      issue(ACS_CLR_SAT, 5'h00, 16'h0000, 8'h00);
      issue(ACS_LOAD_ST, 5'h00, 16'h1800, 8'h00);
      issue(ACS_BR_OV, 5'h00, 16'h0000, 8'h00);
      // Store shifts, legal and ignored codes
      for (int k = 0; k < 6; k++) begin
         issue(ACS_STORE_H, 5'(k), 16'h0000, 8'h20);
      end
      // Move then read back the copy; last address gives no write
      issue(ACS_MOVE, 5'h00, 16'hBEEF, 8'h40);
      issue(ACS_NOP, 5'h00, 16'h0000, 8'h41);
      chk("ram_copy", 32'h0000_BEEF, 32'(ram_rdata));
      issue(ACS_LDT_MOVE, 5'h00, 16'h1234, 8'hFF);
      // Random mix of every opcode, back to back
      for (int n = 0; n < 600; n++) begin
         op = acsalu_op_t'(17'h0_0001 << $urandom_range(0, 16));
         d = 16'($urandom);
         a = ($urandom_range(0, 7) == 0) ? 8'hFF : 8'($urandom);
         issue(op, 5'($urandom_range(0, 17)), d, a);
      end
      issue(ACS_NOP, 5'h00, 16'h0000, 8'h00);
      print_verdict();
   end
endmodule
